//--- logic/modem_pin_pkg.sv
/*
  Constants shared by both ends of the modem pin link.
  Assumes one 100 MHz clock at each end and a bench that joins the ends.
*/
package modem_pin_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int CLK_NS         = 10;
  localparam int RATE_LO_HZ     = 1200;
  localparam int RATE_HI_HZ     = 2400;
  localparam int HALF_LO_CYC    = CLK_HZ / (2 * RATE_LO_HZ);
  localparam int HALF_HI_CYC    = CLK_HZ / (2 * RATE_HI_HZ);
  localparam int FLAG_PULSE_NS  = 1000;
  localparam int FLAG_PULSE_CYC = FLAG_PULSE_NS / CLK_NS;
  localparam int SCLK_HALF_CYC  = 8;
  localparam int GAP_CYC        = 16;

  // ==========================================================
  // Serial word and register map
  localparam int         ADDR_W    = 3;
  localparam int         DATA_W    = 8;
  localparam int         WORD_W    = ADDR_W + DATA_W;
  localparam int         NUM_REGS  = 8;
  localparam int         FIFO_DEPTH = 8;
  localparam logic [2:0] CTRL_ADDR = 3'h0;
  localparam logic [2:0] TEST_ADDR = 3'h7;
  localparam int         HOLD_BIT  = 0;
  localparam int         RATE_BIT  = 1;
  localparam int         FMS_BIT   = 2;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] REG_RST   = 8'h00;

  // ==========================================================
  // Positions of pins in the device synchroniser
  localparam int SI_SCLK = 0;
  localparam int SI_DIR  = 1;
  localparam int SI_SD   = 2;
  localparam int SI_TXD  = 3;
  localparam int SI_AGND = 4;
  localparam int SI_TEST = 5;
  localparam int SI_N    = 6;

  // Host serial sequencer states.
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_WRITE = 3'b001,
    H_RSET  = 3'b010,
    H_READ  = 3'b011,
    H_GAP   = 3'b100
  } host_state_t;

endpackage

//--- logic/modem_pin_if.sv
/*
  Pin bundle between the radio modem device and its host.
  Assumes the bench instantiates it once; the data pin is resolved here.
*/
interface modem_pin_if;
  logic sclk;
  logic dir;
  logic host_sd_o;
  logic host_sd_oe;
  logic dev_sd_o;
  logic dev_sd_oe;
  logic sd;
  logic tx_clk;
  logic tx_data;
  logic rx_flag_n;
  logic agnd_n;
  logic test;

  // Resolve the shared data pin; an undriven pin floats high.
  assign sd = dev_sd_oe ? dev_sd_o : (host_sd_oe ? host_sd_o : 1'b1);

  modport device (
    input  sclk, dir, sd, tx_data, agnd_n, test,
    output dev_sd_o, dev_sd_oe, tx_clk, rx_flag_n
  );
  modport host (
    input  sd, tx_clk, rx_flag_n,
    output sclk, dir, host_sd_o, host_sd_oe, tx_data, agnd_n, test
  );
endinterface

//--- logic/byte_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes a power-of-two depth and a single clock.
*/
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Checks
  // Refuse at elaboration a depth that the pointer logic cannot wrap.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_size
    $error("byte_fifo: depth must be a power of two");
  end

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      wp_d;
  logic [AW:0]      rp_q;
  logic [AW:0]      rp_d;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = !((wp_q[AW] != rp_q[AW]) &&
                       (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem_q[rp_q[AW-1:0]];

  // Next pointers and the written slot.
  always_comb
  begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (in_valid && in_ready)
    begin
      mem_d[wp_q[AW-1:0]] = in_data;
      wp_d = wp_q + 1'b1;
    end
    if (out_valid && out_ready)
      rp_d = rp_q + 1'b1;
  end

  // Register the FIFO state.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      mem_q <= mem_d;
    end
  end
endmodule

//--- logic/modem_pin_device.sv
/*
  Device end of the modem pin link: serial register port, receive
  byte buffer, flag pin and transmit bit clock.
  Assumes link pins are asynchronous to clk and pass a synchroniser.
*/
module modem_pin_device
  import modem_pin_pkg::*;
#(
  parameter int HALF_LO = HALF_LO_CYC,
  parameter int HALF_HI = HALF_HI_CYC,
  parameter int DEPTH   = FIFO_DEPTH
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  modem_pin_if.device      link,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  output logic             rx_bit_ready,
  input  wire logic        frame_seen,
  output logic             tx_bit,
  output logic             tx_bit_strobe,
  output logic [63:0]      ctrl_regs,
  output logic             test_active
);
  localparam int TW = 16;

  // ==========================================================
  // Checks
  // Refuse at elaboration half periods that the divider cannot count.
  if (HALF_HI < 2 || HALF_LO < HALF_HI || HALF_LO >= (1 << TW))
  begin : g_bad_half
    $error("modem_pin_device: bit clock half period out of range");
  end

  // ==========================================================
  // Pin synchroniser
  logic [SI_N-1:0] s1_q;
  logic [SI_N-1:0] s2_q;
  logic [SI_N-1:0] s3_q;
  logic [SI_N-1:0] f_q;
  logic [SI_N-1:0] f_d;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            dir_rise;
  logic            dir_chg;

  // A change counts once the second and third stages agree.
  always_comb
  begin
    for (int i = 0; i < SI_N; i++)
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
    sclk_rise = f_d[SI_SCLK] && !f_q[SI_SCLK];
    sclk_fall = !f_d[SI_SCLK] && f_q[SI_SCLK];
    dir_rise  = f_d[SI_DIR] && !f_q[SI_DIR];
    dir_chg   = f_d[SI_DIR] != f_q[SI_DIR];
  end

  // Register the synchroniser stages.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q  <= '0;
    end
    else
    begin
      s1_q <= {link.test, link.agnd_n, link.tx_data,
               link.sd, link.dir, link.sclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  // ==========================================================
  // Receive byte collector and buffer
  logic [6:0] col_q;
  logic [6:0] col_d;
  logic [2:0] ccnt_q;
  logic [2:0] ccnt_d;
  logic       push;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       pop;
  logic [7:0] fifo_out_data;

  // Eight bits make a byte; a full buffer stalls the bit source.
  always_comb
  begin
    col_d        = col_q;
    ccnt_d       = ccnt_q;
    push         = rx_bit_valid && (ccnt_q == 3'h7);
    rx_bit_ready = (ccnt_q != 3'h7) || fifo_in_ready;
    if (rx_bit_valid && rx_bit_ready)
    begin
      col_d  = {col_q[5:0], rx_bit};
      ccnt_d = ccnt_q + 3'h1;
    end
  end

  // Register the collector.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      col_q  <= '0;
      ccnt_q <= '0;
    end
    else
    begin
      col_q  <= col_d;
      ccnt_q <= ccnt_d;
    end
  end

  byte_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({col_q, rx_bit}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // Serial port and control registers
  logic [3:0]        wcnt_q;
  logic [3:0]        wcnt_d;
  logic [WORD_W-1:0] wsh_q;
  logic [WORD_W-1:0] wsh_d;
  logic [WORD_W-1:0] word;
  logic [7:0]        rd_q;
  logic [7:0]        rd_d;
  logic [7:0]        regs_q [NUM_REGS];
  logic [7:0]        regs_d [NUM_REGS];
  logic [2:0]        waddr;

  // Writes shift in on the seen rise, reads shift out on the fall.
  always_comb
  begin
    wcnt_d = wcnt_q;
    wsh_d  = wsh_q;
    rd_d   = rd_q;
    regs_d = regs_q;
    pop    = 1'b0;
    word   = {wsh_q[WORD_W-2:0], f_q[SI_SD]};
    waddr  = word[WORD_W-1:DATA_W];
    if (dir_chg)
      wcnt_d = '0;
    else if (!f_q[SI_DIR] && sclk_rise)
    begin
      wsh_d = word;
      if (wcnt_q == 4'(WORD_W - 1))
      begin
        wcnt_d = '0;
        if (waddr != TEST_ADDR || f_q[SI_TEST])
          regs_d[waddr] = word[DATA_W-1:0];
      end
      else
        wcnt_d = wcnt_q + 4'h1;
    end
    if (dir_rise)
    begin
      pop  = fifo_out_valid;
      rd_d = fifo_out_valid ? fifo_out_data : 8'h00;
    end
    else if (f_q[SI_DIR] && sclk_fall)
      rd_d = {rd_q[6:0], 1'b0};
    if (!f_q[SI_AGND])
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs_d[i] = (3'(i) == CTRL_ADDR) ? CTRL_RST : REG_RST;
    end
  end

  // Register the serial port state.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wcnt_q <= '0;
      wsh_q  <= '0;
      rd_q   <= '0;
      for (int i = 0; i < NUM_REGS; i++)
        regs_q[i] <= (3'(i) == CTRL_ADDR) ? CTRL_RST : REG_RST;
    end
    else
    begin
      wcnt_q <= wcnt_d;
      wsh_q  <= wsh_d;
      rd_q   <= rd_d;
      regs_q <= regs_d;
    end
  end

  // The pin drives only while the host asks for a read.
  assign link.dev_sd_oe = f_q[SI_DIR];
  assign link.dev_sd_o  = rd_q[7];
  assign test_active    = f_q[SI_TEST];

  for (genvar k = 0; k < NUM_REGS; k++)
  begin : g_flat
    assign ctrl_regs[8*k +: 8] = regs_q[k];
  end

  // ==========================================================
  // Receive flag pin
  logic [7:0] pc_q;
  logic [7:0] pc_d;
  logic       flag_q;
  logic       flag_d;
  logic       fms;

  // Byte mode holds low while bytes wait; frame mode pulses low.
  always_comb
  begin
    fms  = regs_q[CTRL_ADDR][FMS_BIT];
    pc_d = (pc_q != 8'h00) ? pc_q - 8'h01 : 8'h00;
    if (frame_seen)
      pc_d = 8'(FLAG_PULSE_CYC);
    if (fms)
      flag_d = !fifo_out_valid;
    else
      flag_d = (pc_q == 8'h00);
  end

  // Register the flag state.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pc_q   <= '0;
      flag_q <= 1'b1;
    end
    else
    begin
      pc_q   <= pc_d;
      flag_q <= flag_d;
    end
  end

  assign link.rx_flag_n = flag_q;

  // ==========================================================
  // Transmit bit clock and bit capture
  logic [TW-1:0] tc_q;
  logic [TW-1:0] tc_d;
  logic [TW-1:0] half;
  logic          tx_bit_clock_out_q;
  logic          tx_bit_clock_out_d;
  logic          tb_q;
  logic          tb_d;
  logic          ts_q;
  logic          ts_d;

  // Divide clk down to the selected bit rate; hold parks it high.
  always_comb
  begin
    half   = regs_q[CTRL_ADDR][RATE_BIT] ? TW'(HALF_HI - 1)
                                         : TW'(HALF_LO - 1);
    tc_d   = tc_q + 1'b1;
    tx_bit_clock_out_d = tx_bit_clock_out_q;
    tb_d   = tb_q;
    ts_d   = 1'b0;
    if (regs_q[CTRL_ADDR][HOLD_BIT])
    begin
      tc_d   = '0;
      tx_bit_clock_out_d = 1'b1;
    end
    else if (tc_q >= half)
    begin
      tc_d   = '0;
      tx_bit_clock_out_d = !tx_bit_clock_out_q;
      if (!tx_bit_clock_out_q)
      begin
        tb_d = f_q[SI_TXD];
        ts_d = 1'b1;
      end
    end
  end

  // Register the bit clock state.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tc_q   <= '0;
      tx_bit_clock_out_q <= 1'b0;
      tb_q   <= 1'b0;
      ts_q   <= 1'b0;
    end
    else
    begin
      tc_q   <= tc_d;
      tx_bit_clock_out_q <= tx_bit_clock_out_d;
      tb_q   <= tb_d;
      ts_q   <= ts_d;
    end
  end

  assign link.tx_clk   = tx_bit_clock_out_q;
  assign tx_bit        = tb_q;
  assign tx_bit_strobe = ts_q;
endmodule

//--- logic/modem_pin_host.sv
/*
  Host end of the modem pin link: makes the serial clock, writes
  registers, reads received bytes and feeds transmit bits.
  Assumes device outputs are asynchronous and pass a synchroniser.
*/
module modem_pin_host
  import modem_pin_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  modem_pin_if.host        link,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_valid,
  output logic             rd_ready,
  output logic [7:0]       rd_data,
  output logic             rd_done,
  input  wire logic        tx_bit_in,
  output logic             tx_bit_take,
  input  wire logic        reg_reset_req,
  input  wire logic        test_req,
  output logic             rx_flag_n
);
  // ==========================================================
  // Synchroniser for sd, tx clock and flag
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] f_q;
  logic [2:0] f_d;

  // A change counts once the second and third stages agree.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
  end

  // Register the synchroniser; the flag idles high.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 3'h4;
      s2_q <= 3'h4;
      s3_q <= 3'h4;
      f_q  <= 3'h4;
    end
    else
    begin
      s1_q <= {link.rx_flag_n, link.tx_clk, link.sd};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  // ==========================================================
  // Serial sequencer
  host_state_t st_q;
  host_state_t st_d;
  logic [4:0]  ph_q;
  logic [4:0]  ph_d;
  logic [3:0]  bits_q;
  logic [3:0]  bits_d;
  logic [10:0] sh_q;
  logic [10:0] sh_d;
  logic [7:0]  rd_q;
  logic [7:0]  rd_d;
  logic        sclk_q;
  logic        sclk_d;
  logic        dir_q;
  logic        dir_d;
  logic        oe_q;
  logic        oe_d;
  logic        done_q;
  logic        done_d;
  logic        tick;

  assign wr_ready = (st_q == H_IDLE);
  assign rd_ready = (st_q == H_IDLE) && !wr_valid;

  // Clock words out MSB first and bytes in before each fall.
  always_comb
  begin
    st_d   = st_q;
    ph_d   = ph_q + 5'h1;
    bits_d = bits_q;
    sh_d   = sh_q;
    rd_d   = rd_q;
    sclk_d = sclk_q;
    dir_d  = dir_q;
    oe_d   = oe_q;
    done_d = 1'b0;
    tick   = (ph_q == 5'(SCLK_HALF_CYC - 1));
    case (st_q)
      H_IDLE:
      begin
        ph_d = '0;
        if (wr_valid)
        begin
          sh_d   = {wr_addr, wr_data};
          bits_d = 4'(WORD_W);
          dir_d  = 1'b0;
          oe_d   = 1'b1;
          st_d   = H_WRITE;
        end
        else if (rd_valid)
        begin
          bits_d = 4'(DATA_W);
          dir_d  = 1'b1;
          oe_d   = 1'b0;
          st_d   = H_RSET;
        end
      end
      H_WRITE, H_READ:
      begin
        if (tick)
        begin
          ph_d   = '0;
          sclk_d = !sclk_q;
          if (sclk_q)
          begin
            bits_d = bits_q - 4'h1;
            sh_d   = {sh_q[9:0], 1'b0};
            rd_d   = {rd_q[6:0], f_q[0]};
            if (bits_q == 4'h1)
            begin
              oe_d   = 1'b0;
              dir_d  = 1'b0;
              done_d = (st_q == H_READ);
              st_d   = H_GAP;
            end
          end
        end
      end
      H_RSET:
      begin
        if (ph_q == 5'(GAP_CYC - 1))
        begin
          ph_d = '0;
          st_d = H_READ;
        end
      end
      default:
      begin
        if (ph_q == 5'(GAP_CYC - 1))
          st_d = H_IDLE;
      end
    endcase
  end

  // Register the sequencer.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q   <= H_IDLE;
      ph_q   <= '0;
      bits_q <= '0;
      sh_q   <= '0;
      rd_q   <= '0;
      sclk_q <= 1'b0;
      dir_q  <= 1'b0;
      oe_q   <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      ph_q   <= ph_d;
      bits_q <= bits_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      sclk_q <= sclk_d;
      dir_q  <= dir_d;
      oe_q   <= oe_d;
      done_q <= done_d;
    end
  end

  assign link.sclk       = sclk_q;
  assign link.dir        = dir_q;
  assign link.host_sd_oe = oe_q;
  assign link.host_sd_o  = sh_q[10];
  assign rd_data         = rd_q;
  assign rd_done         = done_q;

  // ==========================================================
  // Transmit bits, register reset and test pins
  logic tx_bit_clock_out_seen_q;
  logic txd_q;
  logic take_q;
  logic agnd_q;
  logic test_q;

  // Present a new bit on each seen fall so it is steady at the rise.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_bit_clock_out_seen_q <= 1'b0;
      txd_q       <= 1'b0;
      take_q      <= 1'b0;
      agnd_q      <= 1'b1;
      test_q      <= 1'b0;
    end
    else
    begin
      tx_bit_clock_out_seen_q <= f_q[1];
      take_q      <= tx_bit_clock_out_seen_q && !f_q[1];
      if (tx_bit_clock_out_seen_q && !f_q[1])
        txd_q <= tx_bit_in;
      agnd_q <= !reg_reset_req;
      test_q <= test_req;
    end
  end

  assign link.tx_data = txd_q;
  assign link.agnd_n  = agnd_q;
  assign link.test    = test_q;
  assign tx_bit_take  = take_q;
  assign rx_flag_n    = f_q[2];
endmodule

//--- tb/modem_pin_checker.sv
/*
  Checker for the pins between the modem device and its host.
  Assumes the bench places it beside the pin bundle on the same clock.
*/
module modem_pin_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic dir,
  input wire logic host_sd_oe,
  input wire logic host_sd_o,
  input wire logic dev_sd_oe,
  input wire logic tx_clk,
  input wire logic rx_flag_n
);

  // ==========================================================
  // Timing frame
  // All checks share one clock and stay quiet during reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Phases of the serial clock, of the bit clock and of the flag.
  sequence sclk_hi_s;
    sclk [*7];
  endsequence
  sequence sclk_lo_s;
    !sclk [*7];
  endsequence
  sequence flag_lo_s;
    !rx_flag_n [*8];
  endsequence
  sequence tx_hi_s;
    tx_clk [*8];
  endsequence

  // ==========================================================
  // Pin checks
  // The data pin never has two drivers.
  oe_exclusive_a: assert property (
    !(host_sd_oe && dev_sd_oe))
    else $error("both ends drive the data pin");
  host_dir_a: assert property (
    host_sd_oe |-> !dir)
    else $error("host drives data pin in read direction");
  dev_dir_a: assert property (
    $rose(dev_sd_oe) |-> dir)
    else $error("device drives data pin in write direction");
  dev_release_a: assert property (
    $fell(dir) |-> ##[0:8] !dev_sd_oe)
    else $error("device keeps data pin after direction falls");
  // Each serial clock phase lasts a full half period.
  sclk_high_a: assert property (
    $rose(sclk) |=> sclk_hi_s)
    else $error("serial clock high phase too short");
  sclk_low_a: assert property (
    $fell(sclk) |=> sclk_lo_s)
    else $error("serial clock low phase too short");
  data_stable_a: assert property (
    sclk && $past(sclk) && host_sd_oe |-> $stable(host_sd_o))
    else $error("write data changed while serial clock high");
  tx_high_a: assert property (
    $rose(tx_clk) |=> tx_hi_s)
    else $error("bit clock high phase too short");
  flag_low_a: assert property (
    $fell(rx_flag_n) |=> flag_lo_s)
    else $error("receive flag low too briefly");
endmodule

//--- tb/msk_modem_host_pin_interface_bench.sv
/*
  Self-checking bench joining host and device ends of the modem pins.
  Assumes the device runs with short bit clock halves of 20 and 40.
*/
module msk_modem_host_pin_interface_bench
  import modem_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals and instances
  logic        clk;
  logic        nrst;
  logic        rx_bit;
  logic        rx_bit_valid;
  logic        rx_bit_ready;
  logic        frame_seen;
  logic        tx_bit;
  logic        tx_bit_strobe;
  logic [63:0] ctrl_regs;
  logic        test_active;
  logic        wr_valid;
  logic        wr_ready;
  logic [2:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rd_valid;
  logic        rd_ready;
  logic [7:0]  rd_data;
  logic        rd_done;
  logic        tx_bit_in;
  logic        tx_bit_take;
  logic        reg_reset_req;
  logic        test_req;
  logic        flag_n;
  int          failures;
  int          comparisons;

  modem_pin_if link ();

  modem_pin_device #(.HALF_LO(40), .HALF_HI(20), .DEPTH(8))
    modem_pin_device_inst (.clk(clk), .nrst(nrst), .link(link.device),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .rx_bit_ready(rx_bit_ready), .frame_seen(frame_seen),
    .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .ctrl_regs(ctrl_regs), .test_active(test_active));

  modem_pin_host modem_pin_host_inst (.clk(clk), .nrst(nrst),
    .link(link.host), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .rd_done(rd_done),
    .tx_bit_in(tx_bit_in), .tx_bit_take(tx_bit_take),
    .reg_reset_req(reg_reset_req), .test_req(test_req),
    .rx_flag_n(flag_n));

  modem_pin_checker modem_pin_checker_inst (.clk(clk), .nrst(nrst),
    .sclk(link.sclk), .dir(link.dir), .host_sd_oe(link.host_sd_oe),
    .host_sd_o(link.host_sd_o), .dev_sd_oe(link.dev_sd_oe),
    .tx_clk(link.tx_clk), .rx_flag_n(link.rx_flag_n));

  // 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  // Compares and counts one value.
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  // Writes one register word, then waits out the word and its gap.
  task automatic reg_wr(logic [2:0] a, logic [7:0] d);
    @(negedge clk);
    wr_addr = a;
    wr_data = d;
    wr_valid = 1'b1;
    repeat (300) if (wr_ready !== 1'b1) @(negedge clk);
    chk("wr_ready", 1'b1, wr_ready);
    @(negedge clk);
    wr_valid = 1'b0;
    cyc(220);
  endtask

  // Reads one received byte and compares it.
  task automatic rd_chk(logic [7:0] e);
    @(negedge clk);
    rd_valid = 1'b1;
    repeat (300) if (rd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    rd_valid = 1'b0;
    repeat (300) if (rd_done !== 1'b1) @(posedge clk) #1;
    chk("rd_done", 1'b1, rd_done);
    chk("rd_data", e, rd_data);
    cyc(20);
  endtask

  // Feeds bits hi down to lo of a byte, first bit most significant.
  task automatic rx_bits(logic [7:0] b, int hi, int lo);
    for (int i = hi; i >= lo; i--)
    begin
      @(negedge clk);
      rx_bit = b[i];
      rx_bit_valid = 1'b1;
    end
    @(negedge clk);
    rx_bit_valid = 1'b0;
  endtask

  // Ends the run with the counts and the verdict.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("ctrl_regs", {NUM_REGS{REG_RST}}, ctrl_regs);
    chk("rx_flag_n", 1'b1, link.rx_flag_n);
    chk("dev_sd_oe", 1'b0, link.dev_sd_oe);
    $display("test reset done");
  endtask

  // Test register only takes writes while test access is on.
  task automatic t_test_reg();
    reg_wr(TEST_ADDR, 8'h5a);
    chk("test_reg", REG_RST, ctrl_regs[63:56]);
    test_req = 1'b1;
    cyc(10);
    chk("test_active", 1'b1, test_active);
    reg_wr(TEST_ADDR, 8'h5a);
    chk("test_reg", 8'h5a, ctrl_regs[63:56]);
    test_req = 1'b0;
    $display("test test_reg done");
  endtask

  // Fills the byte buffer until it refuses, then drains it.
  task automatic t_rx_fill();
    reg_wr(CTRL_ADDR, 8'h04);
    chk("ctrl_reg", 8'h04, ctrl_regs[7:0]);
    for (int k = 0; k < 8; k++)
    begin
      rx_bits(8'ha0 + 8'(k), 7, 0);
      cyc(6);
      chk("rx_flag_n", 1'b0, link.rx_flag_n);
    end
    chk("host flag", 1'b0, flag_n);
    rx_bits(8'h3c, 7, 1);
    @(negedge clk);
    rx_bit = 1'b0;
    rx_bit_valid = 1'b1;
    #1 chk("rx_bit_ready", 1'b0, rx_bit_ready);
    @(negedge clk);
    rx_bit_valid = 1'b0;
    for (int k = 0; k < 8; k++)
      rd_chk(8'ha0 + 8'(k));
    cyc(6);
    chk("rx_flag_n", 1'b1, link.rx_flag_n);
    rd_chk(8'h00);
    rx_bits(8'h3c, 0, 0);
    // Let the byte flag stand before reading, as a host reacting to it.
    cyc(10);
    rd_chk(8'h3c);
    $display("test rx_fill done");
  endtask

  // Bit clock rate, transmit bit capture and hold.
  task automatic t_tx_clock();
    time t;
    int  n;
    reg_wr(CTRL_ADDR, 8'h02);
    @(posedge link.tx_clk);
    t = $time;
    @(posedge link.tx_clk);
    chk("tx period", 400, $time - t);
    reg_wr(CTRL_ADDR, 8'h00);
    @(posedge link.tx_clk);
    t = $time;
    @(posedge link.tx_clk);
    chk("tx period", 800, $time - t);
    @(negedge clk);
    tx_bit_in = 1'b1;
    repeat (2) @(posedge tx_bit_strobe);
    @(negedge clk);
    chk("tx_bit", 1'b1, tx_bit);
    tx_bit_in = 1'b0;
    repeat (2) @(posedge tx_bit_strobe);
    @(negedge clk);
    chk("tx_bit", 1'b0, tx_bit);
    // The host takes exactly one new bit per bit clock period.
    n = 0;
    @(posedge tx_bit_strobe);
    repeat (80)
    begin
      @(negedge clk);
      if (tx_bit_take === 1'b1)
        n++;
    end
    chk("tx_bit_take", 1, n);
    reg_wr(CTRL_ADDR, 8'h03);
    chk("tx_clk", 1'b1, link.tx_clk);
    cyc(100);
    chk("tx_clk", 1'b1, link.tx_clk);
    $display("test tx_clock done");
  endtask

  // A frame report gives one low pulse of fixed width.
  task automatic t_frame_flag();
    int n;
    reg_wr(CTRL_ADDR, 8'h00);
    n = 0;
    frame_seen = 1'b1;
    @(negedge clk);
    frame_seen = 1'b0;
    repeat (150)
    begin
      @(negedge clk);
      if (link.rx_flag_n === 1'b0)
        n++;
    end
    chk("flag width", FLAG_PULSE_CYC, n);
    $display("test frame_flag done");
  endtask

  // Holding the ground reference low reloads reset values.
  task automatic t_reg_reset();
    reg_wr(CTRL_ADDR, 8'h06);
    chk("ctrl_reg", 8'h06, ctrl_regs[7:0]);
    reg_reset_req = 1'b1;
    cyc(20);
    chk("ctrl_regs", {NUM_REGS{REG_RST}}, ctrl_regs);
    reg_reset_req = 1'b0;
    cyc(20);
    $display("test reg_reset done");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    failures = 0;
    comparisons = 0;
    nrst = 1'b0;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    frame_seen = 1'b0;
    wr_valid = 1'b0;
    wr_addr = 3'h0;
    wr_data = 8'h00;
    rd_valid = 1'b0;
    tx_bit_in = 1'b0;
    reg_reset_req = 1'b0;
    test_req = 1'b0;
    cyc(5);
    nrst = 1'b1;
    cyc(10);
    t_reset();
    t_test_reg();
    t_rx_fill();
    t_tx_clock();
    t_frame_flag();
    t_reg_reset();
    print_verdict();
  end

  // Cuts a hang short well beyond the expected run time.
  initial
  begin
    #400000;
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    print_verdict();
  end
endmodule
